// *** logic/ccop_device.sv ***
// Purpose: cache coherence operation engine with block and global ops
// Assumes: core keeps write order of base then count, waits on completion
// Notes:   one operation at a time; new starts while busy are dropped
//
// What this block does
// - Software writes base address, then word count.
// - Block op done shows word count zero.
// - Writing one to global register starts it.
// - Global bit 0 high while running, then zero; an APB read of it shows only the L1D invalidate's bit.
// - Set hazard avoided: allocates held during op.
// - Software idles memory and waits for completion.
// - Fence stalls until nothing outstanding remains.
// - Frozen L1D lets traffic run beside writeback-invalidate.
// - Parallel flow: fence, freeze, start, poll, fence, unfreeze.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module ccop_device
  import ccop_pkg::*;
#(
  parameter int GLOBAL_LINES = CCOP_GLOBAL_LINES,
  parameter int WORDS_LINE   = CCOP_WORDS_LINE
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // core side
  ccop_if.device           bus,
  // memory activity from the rest of the memory system
  input  wire logic        ext_pending,
  // status
  output logic [2:0]       active_op
);
  import ccop_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CCOP_ADDR_W-1:0] base_q, base_d;
  logic [CCOP_WC_W-1:0]   wc_q, wc_d;
  ccop_op_t               op_q, op_d;
  logic                   freeze_q, freeze_d;
  logic                   start;
  logic [CCOP_WC_W-1:0]   lines;
  logic                   w_busy;
  logic                   w_step;
  logic                   writeback_invalidate_op_op;

  assign writeback_invalidate_op_op = (op_q == CCOP_OP_L1D_WRITEBACK_INVALIDATE_OP) || (op_q == CCOP_OP_L2_WRITEBACK_INVALIDATE_OP)
                    || (op_q == CCOP_OP_BLOCK);

  always_comb begin
    base_d   = base_q;
    wc_d     = wc_q;
    op_d     = op_q;
    freeze_d = freeze_q;
    start    = 1'b0;
    lines    = '0;
    if (op_q != CCOP_OP_NONE && !w_busy) begin
      op_d = CCOP_OP_NONE;
    end
    if (op_q == CCOP_OP_BLOCK && w_step) begin
      if (wc_q > CCOP_WC_W'(WORDS_LINE)) begin
        wc_d = wc_q - CCOP_WC_W'(WORDS_LINE);
      end else begin
        wc_d = '0;
      end
    end
    if (bus.wr_en && op_q == CCOP_OP_NONE) begin
      case (bus.addr)
        CCOP_DEV_BASE: begin
          base_d = bus.wr_data;
        end
        CCOP_DEV_WCOUNT: begin
          wc_d  = bus.wr_data[CCOP_WC_W-1:0];
          if (bus.wr_data[CCOP_WC_W-1:0] != '0) begin
            op_d  = CCOP_OP_BLOCK;
            start = 1'b1;
            // rounding up in 32 bits so a full count cannot wrap to zero
            lines = CCOP_WC_W'((32'(bus.wr_data[CCOP_WC_W-1:0])
                    + 32'(WORDS_LINE - 1)) / 32'(WORDS_LINE));
          end
        end
        CCOP_DEV_L1D_INV, CCOP_DEV_L1D_WBI,
        CCOP_DEV_L2_INV, CCOP_DEV_L2_WBI: begin
          if (bus.wr_data[CCOP_BUSY_BIT]) begin
            start = 1'b1;
            lines = CCOP_WC_W'(GLOBAL_LINES);
            case (bus.addr)
              CCOP_DEV_L1D_INV: op_d = CCOP_OP_L1D_INV;
              CCOP_DEV_L1D_WBI: op_d = CCOP_OP_L1D_WRITEBACK_INVALIDATE_OP;
              CCOP_DEV_L2_INV:  op_d = CCOP_OP_L2_INV;
              default:          op_d = CCOP_OP_L2_WRITEBACK_INVALIDATE_OP;
            endcase
          end
        end
        default: begin
        end
      endcase
    end
    if (bus.wr_en && bus.addr == CCOP_DEV_FREEZE) begin
      freeze_d = bus.wr_data[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_q   <= '0;
      wc_q     <= CCOP_WC_RESET;
      op_q     <= CCOP_OP_NONE;
      freeze_q <= 1'b0;
    end else begin
      base_q   <= base_d;
      wc_q     <= wc_d;
      op_q     <= op_d;
      freeze_q <= freeze_d;
    end
  end

  // ----------------------------------------------------------------
  // line walk
  // ----------------------------------------------------------------
  // walker pauses while a core transfer is granted, which during an op happens only when frozen
  ccop_line_walker #(.LINE_CYCLES(CCOP_LINE_CYCLES)) u_walk (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (start),
    .count   (lines),
    .hold    (bus.traffic_req && bus.traffic_gnt),
    .busy    (w_busy),
    .step    (w_step),
    .remain  ()
  );

  // ----------------------------------------------------------------
  // traffic gating and fence
  // ----------------------------------------------------------------
  // allocates during an op could hit the same set mid-invalidate, so
  // they wait; a frozen L1D allocates nothing and may run beside writeback_invalidate_op
  assign bus.traffic_gnt = bus.traffic_req &&
                           (op_q == CCOP_OP_NONE ||
                            (freeze_q && writeback_invalidate_op_op));
  assign bus.mem_busy    = (op_q != CCOP_OP_NONE) || ext_pending;
  assign bus.fence_stall = bus.fence_req && bus.mem_busy;

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  always_comb begin
    bus.rd_data = '0;
    case (bus.addr)
      CCOP_DEV_BASE:    bus.rd_data = base_q;
      CCOP_DEV_WCOUNT:  bus.rd_data = 32'(wc_q);
      CCOP_DEV_L1D_INV: bus.rd_data[0] = (op_q == CCOP_OP_L1D_INV);
      CCOP_DEV_L1D_WBI: bus.rd_data[0] = (op_q == CCOP_OP_L1D_WRITEBACK_INVALIDATE_OP);
      CCOP_DEV_L2_INV:  bus.rd_data[0] = (op_q == CCOP_OP_L2_INV);
      CCOP_DEV_L2_WBI:  bus.rd_data[0] = (op_q == CCOP_OP_L2_WRITEBACK_INVALIDATE_OP);
      CCOP_DEV_FREEZE:  bus.rd_data[0] = freeze_q;
      default:          bus.rd_data = '0;
    endcase
  end

  assign active_op = op_q;
endmodule
`default_nettype wire

// *** shared/ccop_pkg.sv ***
// Purpose: shared constants and types for the cache coherence op controller
// Assumes: 32-bit register data, one aligned word per register
// Notes:   APB offsets are byte addresses; device offsets are register indices on its own port
package ccop_pkg;

  // ----------------------------------------------------------------
  // operation kinds
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCOP_OP_NONE,
    CCOP_OP_BLOCK,
    CCOP_OP_L1D_INV,
    CCOP_OP_L1D_WRITEBACK_INVALIDATE_OP,
    CCOP_OP_L2_INV,
    CCOP_OP_L2_WRITEBACK_INVALIDATE_OP
  } ccop_op_t;

  // ----------------------------------------------------------------
  // register map of the device, as seen on its own port
  // ----------------------------------------------------------------
  localparam logic [2:0] CCOP_DEV_BASE    = 3'h0;
  localparam logic [2:0] CCOP_DEV_WCOUNT  = 3'h1;
  localparam logic [2:0] CCOP_DEV_L1D_INV = 3'h2;
  localparam logic [2:0] CCOP_DEV_L1D_WBI = 3'h3;
  localparam logic [2:0] CCOP_DEV_L2_INV  = 3'h4;
  localparam logic [2:0] CCOP_DEV_L2_WBI  = 3'h5;
  localparam logic [2:0] CCOP_DEV_FREEZE  = 3'h6;

  localparam int         CCOP_WC_W       = 16;
  localparam int         CCOP_ADDR_W     = 32;
  localparam logic [CCOP_WC_W-1:0] CCOP_WC_RESET = 16'h0000;
  localparam int         CCOP_BUSY_BIT   = 0;
  localparam int         CCOP_WORDS_LINE = 16;
  localparam int         CCOP_GLOBAL_LINES = 64;
  localparam int         CCOP_LINE_CYCLES  = 2;

  // ----------------------------------------------------------------
  // controller APB map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CCOP_APB_BASE   = 8'h00;
  localparam logic [7:0] CCOP_APB_WCOUNT = 8'h04;
  localparam logic [7:0] CCOP_APB_GLOBAL = 8'h08;
  localparam logic [7:0] CCOP_APB_FREEZE = 8'h0C;
  localparam logic [7:0] CCOP_APB_STATUS = 8'h10;
  localparam logic [7:0] CCOP_APB_FENCE  = 8'h14;

  localparam int         CCOP_GSEL_LSB   = 0;
  localparam int         CCOP_STAT_BUSY  = 0;
  localparam int         CCOP_STAT_FENCE = 1;
  localparam int         CCOP_STAT_FROZEN = 2;
  localparam int         CCOP_STAT_DONE  = 3;

endpackage

// *** shared/ccop_if.sv ***
// Purpose: register port between core-side controller and coherence device
// Assumes: single clock, one request per cycle, answer in the same cycle
// Notes:   rd_data is combinational from device registers
`timescale 1ns/100ps
`default_nettype none
interface ccop_if;
  import ccop_pkg::*;
  logic                   wr_en;
  logic                   rd_en;
  logic [2:0]             addr;
  logic [31:0]            wr_data;
  logic [31:0]            rd_data;
  logic                   mem_busy;
  logic                   fence_req;
  logic                   fence_stall;
  logic                   traffic_req;
  logic                   traffic_gnt;

  modport device (
    input  wr_en, rd_en, addr, wr_data, fence_req, traffic_req,
    output rd_data, mem_busy, fence_stall, traffic_gnt
  );
  modport core (
    output wr_en, rd_en, addr, wr_data, fence_req, traffic_req,
    input  rd_data, mem_busy, fence_stall, traffic_gnt
  );
endinterface
`default_nettype wire

// *** logic/ccop_line_walker.sv ***
// Purpose: steps through cache lines of one coherence operation
// Assumes: start is a one-cycle pulse while idle
// Notes:   a fixed number of cycles per line models the line access
`timescale 1ns/100ps
`default_nettype none
module ccop_line_walker
  import ccop_pkg::*;
#(
  parameter int LINE_CYCLES = CCOP_LINE_CYCLES
) (
  // clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // control
  input  wire logic                 start,
  input  wire logic [CCOP_WC_W-1:0] count,
  input  wire logic                 hold,
  // progress
  output logic                      busy,
  output logic                      step,
  output logic [CCOP_WC_W-1:0]      remain
);
  localparam int CW = $clog2(LINE_CYCLES + 1);

  logic [CCOP_WC_W-1:0] remain_q, remain_d;
  logic [CW-1:0]        tick_q, tick_d;
  logic                 step_c;

  always_comb begin
    remain_d = remain_q;
    tick_d   = tick_q;
    step_c   = 1'b0;
    if (start) begin
      remain_d = count;
      tick_d   = '0;
    end else if (remain_q != '0 && !hold) begin
      if (tick_q == CW'(LINE_CYCLES - 1)) begin
        tick_d   = '0;
        step_c   = 1'b1;
        remain_d = remain_q - 1'b1;
      end else begin
        tick_d = tick_q + 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain_q <= '0;
      tick_q   <= '0;
    end else begin
      remain_q <= remain_d;
      tick_q   <= tick_d;
    end
  end

  assign busy   = (remain_q != '0);
  assign step   = step_c;
  assign remain = remain_q;
endmodule
`default_nettype wire

// *** logic/ccop_core.sv ***
// Purpose: core-side controller: APB registers drive the device port
// Assumes: software follows the documented sequences
// Notes:   APB answers in the access cycle, pslverr on unmapped address
`timescale 1ns/100ps
`default_nettype none
module ccop_core
  import ccop_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // device side
  ccop_if.core             dev,
  // core memory traffic
  input  wire logic        traffic_req,
  output logic             traffic_gnt
);
  import ccop_pkg::*;

  logic        acc;
  logic        mapped;
  logic        fence_q, fence_d;
  logic        done_q, done_d;
  logic [31:0] rdata_d;
  logic [2:0]  gsel;

  assign acc    = psel && penable;
  assign mapped = paddr == CCOP_APB_BASE || paddr == CCOP_APB_WCOUNT ||
                  paddr == CCOP_APB_GLOBAL || paddr == CCOP_APB_FREEZE ||
                  paddr == CCOP_APB_STATUS || paddr == CCOP_APB_FENCE;
  assign gsel   = pwdata[CCOP_GSEL_LSB +: 3];
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;

  // ----------------------------------------------------------------
  // device request mapping
  // ----------------------------------------------------------------
  always_comb begin
    dev.wr_en   = 1'b0;
    dev.rd_en   = 1'b0;
    dev.addr    = CCOP_DEV_WCOUNT;
    dev.wr_data = pwdata;
    case (paddr)
      CCOP_APB_BASE:   dev.addr = CCOP_DEV_BASE;
      CCOP_APB_FREEZE: dev.addr = CCOP_DEV_FREEZE;
      CCOP_APB_GLOBAL: dev.addr = pwrite ? 3'(CCOP_DEV_L1D_INV + 3'(gsel[1:0]))
                                         : CCOP_DEV_L1D_INV;
      default:         dev.addr = CCOP_DEV_WCOUNT;
    endcase
    if (paddr == CCOP_APB_GLOBAL && pwrite) begin
      dev.wr_data = {31'h0000_0000, gsel[2]};
    end
    if (acc && mapped && paddr != CCOP_APB_STATUS &&
        paddr != CCOP_APB_FENCE) begin
      dev.wr_en = pwrite;
      dev.rd_en = !pwrite;
    end
  end

  // ----------------------------------------------------------------
  // fence and status
  // ----------------------------------------------------------------
  always_comb begin
    fence_d = fence_q;
    done_d  = done_q;
    if (acc && pwrite && paddr == CCOP_APB_FENCE) begin
      fence_d = 1'b1;
    end else if (fence_q && !dev.fence_stall) begin
      fence_d = 1'b0;
      done_d  = 1'b1;
    end
    if (acc && !pwrite && paddr == CCOP_APB_STATUS && !(fence_q &&
        !dev.fence_stall)) begin
      done_d = 1'b0;
    end
    rdata_d = dev.rd_data;
    if (paddr == CCOP_APB_STATUS) begin
      rdata_d = '0;
      rdata_d[CCOP_STAT_BUSY]   = dev.mem_busy;
      rdata_d[CCOP_STAT_FENCE]  = fence_q;
      rdata_d[CCOP_STAT_DONE]   = done_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fence_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      fence_q <= fence_d;
      done_q  <= done_d;
    end
  end

  assign prdata          = (acc && !pwrite && mapped) ? rdata_d : '0;
  assign dev.fence_req   = fence_q;
  assign dev.traffic_req = traffic_req;
  assign traffic_gnt     = dev.traffic_gnt;
endmodule
`default_nettype wire

// *** verification/ccop_chk.sv ***
// Purpose: checks on the port between core-side controller and device
// Assumes: one clock domain, reset asynchronous and active low
// Notes:   sees interface signals only; freeze state is shadowed here
`timescale 1ns/100ps
`default_nettype none
module ccop_chk
  import ccop_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // device port
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [2:0]  addr,
  input  wire logic [31:0] wr_data,
  input  wire logic [31:0] rd_data,
  input  wire logic        mem_busy,
  input  wire logic        fence_req,
  input  wire logic        fence_stall,
  input  wire logic        traffic_req,
  input  wire logic        traffic_gnt
);
  logic frz_q;
  logic frz_d;
  logic wbi_q;
  logic wbi_d;
  // --------------------------------------------------------------
  // freeze shadow, since the port has no freeze wire
  // --------------------------------------------------------------
  always_comb begin
    frz_d = frz_q;
    wbi_d = wbi_q;
    if (wr_en && addr == CCOP_DEV_FREEZE) begin
      frz_d = wr_data[0];
    end
    // global writeback-invalidate shadow, dropped once the port is idle
    if (!mem_busy) begin
      wbi_d = 1'b0;
    end
    if (wr_en && !mem_busy && wr_data[0] &&
        (addr == CCOP_DEV_L1D_WBI || addr == CCOP_DEV_L2_WBI)) begin
      wbi_d = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frz_q <= 1'b0;
      wbi_q <= 1'b0;
    end else begin
      frz_q <= frz_d;
      wbi_q <= wbi_d;
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // --------------------------------------------------------------
  // properties
  // --------------------------------------------------------------
  a_block_starts_busy: assert property (
    wr_en && addr == CCOP_DEV_WCOUNT && wr_data[15:0] != 16'h0000
      && !mem_busy |=> mem_busy[*2])
    else $error("block op did not start");
  a_idle_count_zero: assert property (
    rd_en && addr == CCOP_DEV_WCOUNT && !mem_busy
      |-> rd_data[15:0] == 16'h0000)
    else $error("word count not zero when idle");
  a_global_bit_held: assert property (
    wr_en && addr == CCOP_DEV_L1D_INV && wr_data[0] && !mem_busy
      |=> mem_busy[*8])
    else $error("global op ended too soon");
  a_inv_blocks_traffic: assert property (
    wr_en && addr == CCOP_DEV_L1D_INV && wr_data[0] && !mem_busy
      |=> !traffic_gnt[*8])
    else $error("traffic granted during invalidate");
  a_frozen_traffic_runs: assert property (
    frz_q && wbi_q && traffic_req |-> traffic_gnt)
    else $error("frozen traffic not granted");
  a_idle_grant: assert property (
    !mem_busy |-> traffic_gnt == traffic_req)
    else $error("idle grant does not follow request");
  a_fence_holds: assert property (
    fence_req && mem_busy |-> fence_stall)
    else $error("fence released while busy");
  a_fence_frees: assert property (
    fence_req && !mem_busy |-> !fence_stall)
    else $error("fence stalls with nothing outstanding");
endmodule
`default_nettype wire

// *** verification/cache_coherence_op_control_tb.sv ***
// Purpose: self-checking bench for both ends of the coherence op block
// Assumes: zero-wait APB slave, short global ops via GLOBAL_LINES
// Notes:   expectations come from a small integer model in here
`timescale 1ns/100ps
`default_nettype none
module cache_coherence_op_control_tb;
  import ccop_pkg::*;
  localparam int GL = 8;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        traffic_req = 1'b0;
  logic        traffic_gnt;
  logic        ext_pending = 1'b0;
  logic [2:0]  active_op;
  logic [31:0] rdat;
  logic        rerr;
  logic        ok;
  int          nw;
  int          prev;
  int          num_errors = 0;
  int          checks = 0;
  logic [7:0]  rst_regs [4] = '{CCOP_APB_WCOUNT, CCOP_APB_GLOBAL,
                                 CCOP_APB_FREEZE, CCOP_APB_STATUS};
  ccop_if bus_if ();
  ccop_core ccop_core_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev(bus_if.core), .traffic_req(traffic_req),
    .traffic_gnt(traffic_gnt));
  ccop_device #(.GLOBAL_LINES(GL)) ccop_device_i (.pclk(pclk),
    .presetn(presetn), .bus(bus_if.device), .ext_pending(ext_pending),
    .active_op(active_op));
  ccop_chk ccop_chk_i (.pclk(pclk), .presetn(presetn),
    .wr_en(bus_if.wr_en), .rd_en(bus_if.rd_en), .addr(bus_if.addr),
    .wr_data(bus_if.wr_data), .rd_data(bus_if.rd_data),
    .mem_busy(bus_if.mem_busy), .fence_req(bus_if.fence_req),
    .fence_stall(bus_if.fence_stall), .traffic_req(bus_if.traffic_req),
    .traffic_gnt(bus_if.traffic_gnt));
  always #2.5 pclk = ~pclk;
  // --------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string msg);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // this wait ends once pready is high; only the watchdog ends it otherwise
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // polling the status word is the software wait for completion
  task automatic wait_idle();
    int n = 0;
    do begin
      apb(1'b0, CCOP_APB_STATUS, 32'h0000_0000);
      n++;
    end while (rdat[CCOP_STAT_BUSY] !== 1'b0 && n < 300);
    chk(n < 300, 1'b1, "op never finished");
  endtask
  task automatic tally_and_finish();
    if (num_errors == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge pclk);
    num_errors++;
    tally_and_finish();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial begin
    void'($urandom(32'h0b06));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_regs[i]) begin
      apb(1'b0, rst_regs[i], 32'h0000_0000);
      chk(rdat, 32'h0000_0000, "reset value");
      chk(rerr, 1'b0, "mapped read refused");
    end
    apb(1'b1, 8'h18, $urandom());
    chk(rerr, 1'b1, "unmapped write accepted");
    // block ops; a second count write while busy must be dropped
    for (int k = 0; k < 3; k++) begin
      nw = $urandom_range(48, 200);
      apb(1'b1, CCOP_APB_BASE, $urandom());
      apb(1'b1, CCOP_APB_WCOUNT, 32'(nw));
      apb(1'b1, CCOP_APB_WCOUNT, 32'h0000_ffff);
      chk(32'(active_op), 32'(CCOP_OP_BLOCK), "block not active");
      prev = nw;
      for (int n = 0; n < 100 && prev != 0; n++) begin
        apb(1'b0, CCOP_APB_WCOUNT, 32'h0000_0000);
        ok = rdat <= prev &&
             (rdat == 0 || (nw - rdat) % CCOP_WORDS_LINE == 0);
        chk(ok, 1'b1, "word count step");
        prev = (rdat === 32'h0000_0000) ? 0 : int'(rdat);
      end
      chk(rdat, 32'h0000_0000, "block op not done");
      wait_idle();
    end
    // every global op, with and without freeze
    for (int s = 0; s < 8; s++) begin
      apb(1'b1, CCOP_APB_FENCE, 32'h0000_0000);
      apb(1'b1, CCOP_APB_FREEZE, 32'(s / 4));
      apb(1'b1, CCOP_APB_GLOBAL, 32'(4 + s % 4));
      apb(1'b0, CCOP_APB_GLOBAL, 32'h0000_0000);
      chk(rdat[0], s % 4 == 0, "global busy bit");
      chk(32'(active_op), 32'(int'(CCOP_OP_L1D_INV) + s % 4),
          "global op kind");
      traffic_req <= 1'b1;
      @(posedge pclk);
      @(posedge pclk);
      chk(traffic_gnt, s / 4 == 1 && s % 2 == 1, "grant");
      traffic_req <= 1'b0;
      wait_idle();
      apb(1'b0, CCOP_APB_GLOBAL, 32'h0000_0000);
      chk(rdat[0], 1'b0, "global bit not cleared");
      apb(1'b1, CCOP_APB_FENCE, 32'h0000_0000);
      apb(1'b1, CCOP_APB_FREEZE, 32'h0000_0000);
    end
    // the last fence left done set; this read also clears it
    apb(1'b0, CCOP_APB_STATUS, 32'h0000_0000);
    chk(rdat[3:0], 4'h8, "last fence not done");
    // fence held off by outside memory activity
    ext_pending <= 1'b1;
    apb(1'b1, CCOP_APB_FENCE, 32'h0000_0000);
    apb(1'b0, CCOP_APB_STATUS, 32'h0000_0000);
    chk(rdat[3:0], 4'h3, "fence not pending");
    repeat ($urandom_range(1, 20)) @(posedge pclk);
    ext_pending <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, CCOP_APB_STATUS, 32'h0000_0000);
    chk(rdat[3:0], 4'h8, "fence not done");
    apb(1'b0, CCOP_APB_STATUS, 32'h0000_0000);
    chk(rdat[3:0], 4'h0, "done not cleared by read");
    tally_and_finish();
  end
endmodule
`default_nettype wire
